// ### hw/mac_map.svh
`ifndef MAC_MAP_SVH
`define MAC_MAP_SVH

// ----------------------------------------------------------------
// mode values written by mode_write_instr
// ----------------------------------------------------------------
`define MAC_MODE_INIT0 8'h00
`define MAC_MODE_INIT1 8'h01
`define MAC_MODE_INIT2 8'h02
`define MAC_MODE_RD_ACC_LO 8'h03
`define MAC_MODE_RD_ACC_HI 8'h13
`define MAC_MODE_RD_SEC_LO 8'h23
`define MAC_MODE_RD_SEC_HI 8'h33
`define MAC_MODE_UMAC_LO 8'h06
`define MAC_MODE_SMAC_LO 8'h07
`define MAC_MODE_UMAC_HI 8'h16
`define MAC_MODE_SMAC_HI 8'h17

// ----------------------------------------------------------------
// mode field positions
// ----------------------------------------------------------------
`define MAC_MODE_SIGNED_BIT 0
`define MAC_MODE_HIGH_BIT 4
`define MAC_MODE_SEC_BIT 5

// ----------------------------------------------------------------
// flag values and reset values
// ----------------------------------------------------------------
`define MAC_FLAGS_NONE 4'h0
`define MAC_FLAGS_OVF 4'h4
`define MAC_RESULT_RST 32'h0000_0000
`define MAC_HALF_RST 16'h0000
`define MAC_MODE_RST 8'h00

`endif

// ### hw/mac_pkg.sv
package mac_pkg;

    // one instruction from the core, same clock domain
    typedef struct packed {
        logic mode_wr;
        logic load_op;
        logic compute;
        logic imm_ext;
        logic [7:0] mode_val;
        logic [15:0] dst_val;
        logic [15:0] src_val;
        logic [15:0] imm_val;
    } instr_t;

    // answer returned for a compute_and_return_instr
    typedef struct packed {
        logic valid;
        logic [3:0] flags;
        logic [15:0] data;
    } answer_t;

    typedef enum logic [5:0] {
        CL_INIT0 = 6'h01,
        CL_INIT1 = 6'h02,
        CL_INIT2 = 6'h04,
        CL_READ = 6'h08,
        CL_MAC = 6'h10,
        CL_OTHER = 6'h20
    } mode_class_t;

endpackage

// ### hw/mac_multiplier.sv
`include "mac_map.svh"

module mac_multiplier (
    // operands
    input wire logic i_signed,
    input wire logic [15:0] i_mul_a,
    input wire logic [15:0] i_mul_b,
    input wire logic [31:0] i_acc,
    // results
    output logic [31:0] o_product,
    output logic [31:0] o_sum,
    output logic o_overflow
);
    wire [16:0] a_ext = {i_signed & i_mul_a[15], i_mul_a};
    wire [16:0] b_ext = {i_signed & i_mul_b[15], i_mul_b};
    wire signed [33:0] prod_full = $signed(a_ext) * $signed(b_ext);

    assign o_product = prod_full[31:0];
    assign o_sum = i_acc + o_product;
    // like signs in, opposite sign out; unsigned never overflows
    assign o_overflow = i_signed & (o_product[31] == i_acc[31])
        & (o_sum[31] != o_product[31]);
endmodule

// ### hw/mac_half_select.sv
`include "mac_map.svh"

module mac_half_select (
    // selection
    input wire logic i_sel_sec,
    input wire logic i_sel_hi,
    // words
    input wire logic [31:0] i_acc,
    input wire logic [31:0] i_sec,
    // half word
    output logic [15:0] o_half
);
    wire [31:0] word = i_sel_sec ? i_sec : i_acc;

    assign o_half = i_sel_hi ? word[31:16] : word[15:0];
endmodule

// ### hw/mac_coprocessor_datapath.sv
`include "mac_map.svh"

// Behaviour
// (RL1) a MAC step adds a 16x16 product into the 32-bit accumulator.
// (RL2) writing mode 0x00 clears both result registers, no operand needed.
// (RL3) in mode 0x01 a load puts the source low and zeros the high half.
// (RL4) in mode 0x02 a load puts the destination high and the source low.
// (RL5) modes 0x06 and 0x07 accumulate and return the new sum's low half.
// (RL6) modes 0x16 and 0x17 accumulate and return the new sum's high half.
// (RL7) flags read 0100 on signed overflow only, otherwise 0000.
// (RL8) overflow: product and old sum share a sign the new sum lacks.
// (RL9) while the overflow flag is set the accumulated result is held.
// (RL10) overflow clears on a clean MAC step or any non-read load or compute.
// (RL11) each compute returns one half plus flags; read-back gives the other.
// (RL12) result registers hold until an operation rewrites them.
// (RL13) read-back: 0x03/0x13 acc low/high, 0x23/0x33 secondary low/high.
// (RL14) read-back reports flags 0000 and leaves both result registers alone.
// (RL15) the core initialises, picks a MAC mode, computes per pair, reads.
// (RL16) the core writes the mode before sending operands for it.
// (RL17) signed modes use two's complement; an immediate replaces the source.
module mac_coprocessor_datapath (
    // clock, reset, enable
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    input wire logic i_clk_en,
    // instruction from the core
    input wire mac_pkg::instr_t i_instr,
    // answer to the core
    output mac_pkg::answer_t o_answer,
    // status
    output logic [7:0] o_mode,
    output logic o_overflow,
    output logic [31:0] o_accumulator,
    output logic [31:0] o_secondary
);
    // ------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------
    function automatic mac_pkg::mode_class_t classify(input logic [7:0] m);
        mac_pkg::mode_class_t c;
        c = mac_pkg::CL_OTHER;
        unique case (m)
            `MAC_MODE_INIT0: c = mac_pkg::CL_INIT0;
            `MAC_MODE_INIT1: c = mac_pkg::CL_INIT1;
            `MAC_MODE_INIT2: c = mac_pkg::CL_INIT2;
            `MAC_MODE_RD_ACC_LO,
            `MAC_MODE_RD_ACC_HI,
            `MAC_MODE_RD_SEC_LO,
            `MAC_MODE_RD_SEC_HI: c = mac_pkg::CL_READ;
            `MAC_MODE_UMAC_LO,
            `MAC_MODE_SMAC_LO,
            `MAC_MODE_UMAC_HI,
            `MAC_MODE_SMAC_HI: c = mac_pkg::CL_MAC;
            default: c = mac_pkg::CL_OTHER;
        endcase
        return c;
    endfunction

    logic [7:0] mode_reg;
    mac_pkg::mode_class_t class_reg;
    logic [31:0] acc_reg;
    logic [31:0] sec_reg;
    logic ovf_reg;
    mac_pkg::answer_t ans_reg;
    logic en_q_reg;

    logic [7:0] mode_next;
    mac_pkg::mode_class_t class_next;
    logic [31:0] acc_next;
    logic [31:0] sec_next;
    logic ovf_next;
    mac_pkg::answer_t ans_next;

    // ------------------------------------------------------------
    // instruction decode
    // ------------------------------------------------------------
    // one instruction per cycle; a mode write wins over a load,
    // and a load over a compute, should the core assert several
    wire mode_wr_w = i_instr.mode_wr;
    wire load_w = i_instr.load_op & ~mode_wr_w;
    wire compute_w = i_instr.compute & ~mode_wr_w & ~i_instr.load_op;
    wire init0_wr_w = mode_wr_w
        & (classify(i_instr.mode_val) == mac_pkg::CL_INIT0); // RL2

    wire is_init1 = class_reg == mac_pkg::CL_INIT1;
    wire is_init2 = class_reg == mac_pkg::CL_INIT2;
    wire is_read = class_reg == mac_pkg::CL_READ;
    wire is_mac = class_reg == mac_pkg::CL_MAC;

    wire signed_w = is_mac & mode_reg[`MAC_MODE_SIGNED_BIT]; // RL17
    wire high_w = mode_reg[`MAC_MODE_HIGH_BIT];
    wire sec_sel_w = is_read & mode_reg[`MAC_MODE_SEC_BIT];

    // immediate form replaces the source register operand
    wire [15:0] operand_w = i_instr.imm_ext ? i_instr.imm_val
        : i_instr.src_val; // RL17

    wire mac_step_w = compute_w & is_mac;
    // a set flag freezes the sum for one step; that step clears it
    wire mac_acc_w = mac_step_w & ~ovf_reg; // RL9
    wire clr_w = (load_w | compute_w) & ~is_read; // RL10

    // ------------------------------------------------------------
    // arithmetic and result selection
    // ------------------------------------------------------------
    logic [31:0] product_w;
    logic [31:0] sum_w;
    logic mul_ovf_w;
    logic [15:0] half_w;

    mac_multiplier u_mul (
        .i_signed(signed_w),
        .i_mul_a(i_instr.dst_val),
        .i_mul_b(operand_w),
        .i_acc(acc_reg),
        .o_product(product_w),
        .o_sum(sum_w),
        .o_overflow(mul_ovf_w)
    );

    // a MAC step returns a half of the updated accumulator
    mac_half_select u_sel (
        .i_sel_sec(sec_sel_w),
        .i_sel_hi(high_w),
        .i_acc(is_mac ? acc_next : acc_reg),
        .i_sec(sec_reg),
        .o_half(half_w)
    ); // RL11 RL13

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    assign mode_next = mode_wr_w ? i_instr.mode_val : mode_reg; // RL16
    assign class_next = mode_wr_w ? classify(i_instr.mode_val)
        : class_reg;

    assign acc_next =
        init0_wr_w ? `MAC_RESULT_RST : // RL2
        (load_w & is_init1) ? {`MAC_HALF_RST, operand_w} : // RL3
        (load_w & is_init2) ? {i_instr.dst_val, operand_w} : // RL4
        mac_acc_w ? sum_w : // RL1
        acc_reg; // RL12

    assign sec_next = init0_wr_w ? `MAC_RESULT_RST : sec_reg; // RL2

    // mode 0x00 also drops a pending overflow, as its result is gone
    assign ovf_next =
        init0_wr_w ? 1'b0 :
        mac_step_w ? (~ovf_reg & mul_ovf_w) : // RL8 RL10
        clr_w ? 1'b0 : // RL10
        ovf_reg;

    // flags are zero except on an overflowing signed step
    assign ans_next.valid = compute_w;
    assign ans_next.flags = !compute_w ? ans_reg.flags :
        (mac_acc_w & mul_ovf_w) ? `MAC_FLAGS_OVF : // RL7
        `MAC_FLAGS_NONE; // RL14
    assign ans_next.data = compute_w ? half_w : ans_reg.data; // RL5 RL6

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            mode_reg <= `MAC_MODE_RST;
            class_reg <= mac_pkg::CL_INIT0;
            acc_reg <= `MAC_RESULT_RST;
            sec_reg <= `MAC_RESULT_RST;
            ovf_reg <= 1'b0;
            ans_reg <= '0;
        end else if (i_clk_en) begin
            mode_reg <= mode_next;
            class_reg <= class_next;
            acc_reg <= acc_next;
            sec_reg <= sec_next;
            ovf_reg <= ovf_next;
            ans_reg <= ans_next;
        end
    end

    // valid is a one-cycle pulse even if the enable drops next cycle
    assign o_answer.valid = ans_reg.valid & en_q_reg;
    assign o_answer.flags = ans_reg.flags;
    assign o_answer.data = ans_reg.data;
    assign o_mode = mode_reg;
    assign o_overflow = ovf_reg;
    assign o_accumulator = acc_reg;
    assign o_secondary = sec_reg;

    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            en_q_reg <= 1'b0;
        end else begin
            en_q_reg <= i_clk_en;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_sys_rst);

    wire step_w = i_clk_en & mac_acc_w;

    a_init0_clear: assert property ( // RL2
        i_clk_en & init0_wr_w |=> acc_reg == `MAC_RESULT_RST
            && sec_reg == `MAC_RESULT_RST && !ovf_reg)
        else $error("mode 0x00 did not clear results");

    a_init1_load: assert property ( // RL3
        i_clk_en & load_w & is_init1
            |=> acc_reg == {`MAC_HALF_RST, $past(operand_w)})
        else $error("init 1 load wrong");

    a_init2_load: assert property ( // RL4
        i_clk_en & load_w & is_init2
            |=> acc_reg == {$past(i_instr.dst_val), $past(operand_w)})
        else $error("init 2 load wrong");

    a_mac_sum: assert property ( // RL1
        step_w |=> acc_reg == $past(acc_reg) + $past(product_w))
        else $error("accumulation wrong");

    a_mac_low_half: assert property ( // RL5
        step_w & ~high_w |=> o_answer.valid
            && o_answer.data == acc_reg[15:0])
        else $error("low half not returned");

    a_mac_high_half: assert property ( // RL6
        step_w & high_w |=> o_answer.valid
            && o_answer.data == acc_reg[31:16])
        else $error("high half not returned");

    a_unsigned_no_ovf: assert property ( // RL7
        i_clk_en & mac_step_w & ~signed_w
            |=> o_answer.flags == `MAC_FLAGS_NONE && !ovf_reg)
        else $error("unsigned step flagged overflow");

    a_signed_ovf_set: assert property ( // RL8
        step_w & signed_w & (product_w[31] == acc_reg[31])
            & (sum_w[31] != product_w[31])
            |=> ovf_reg && o_answer.flags == `MAC_FLAGS_OVF)
        else $error("signed overflow missed");

    a_ovf_hold: assert property ( // RL9
        i_clk_en & mac_step_w & ovf_reg
            |=> acc_reg == $past(acc_reg) && !ovf_reg)
        else $error("result moved while overflow held");

    a_ovf_clear: assert property ( // RL10
        i_clk_en & ovf_reg & clr_w |=> !ovf_reg)
        else $error("overflow flag not cleared");

    a_read_sec_low: assert property ( // RL13
        i_clk_en & compute_w & (mode_reg == `MAC_MODE_RD_SEC_LO)
            |=> o_answer.data == sec_reg[15:0])
        else $error("secondary low half not returned");

    a_read_acc_high: assert property ( // RL13
        i_clk_en & compute_w & (mode_reg == `MAC_MODE_RD_ACC_HI)
            |=> o_answer.data == acc_reg[31:16])
        else $error("accumulator high half not returned");

    a_read_static: assert property ( // RL14
        i_clk_en & compute_w & is_read
            |=> $stable(acc_reg) && $stable(sec_reg)
            && o_answer.flags == `MAC_FLAGS_NONE)
        else $error("read-back disturbed results");

    a_results_retain: assert property ( // RL12
        !i_clk_en || !(i_instr.mode_wr | i_instr.load_op
            | i_instr.compute)
            |=> $stable(acc_reg) && $stable(sec_reg))
        else $error("results changed without an operation");

    a_read_acc_low: assert property ( // RL13
        i_clk_en & compute_w & (mode_reg == `MAC_MODE_RD_ACC_LO)
            |=> o_answer.data == acc_reg[15:0])
        else $error("accumulator low half not returned");

    a_read_sec_high: assert property ( // RL13
        i_clk_en & compute_w & (mode_reg == `MAC_MODE_RD_SEC_HI)
            |=> o_answer.data == sec_reg[31:16])
        else $error("secondary high half not returned");

    a_answer_pulse: assert property ( // RL11
        !(i_clk_en & compute_w) |=> !o_answer.valid)
        else $error("answer without a taken compute");

    a_answer_hold: assert property ( // RL11
        !(i_clk_en & compute_w)
            |=> $stable(o_answer.data) && $stable(o_answer.flags))
        else $error("answer changed without a compute");

    a_enable_freeze: assert property ( // RL12
        !i_clk_en
            |=> $stable(mode_reg) && $stable(acc_reg) && $stable(ovf_reg))
        else $error("state moved with the enable low");

    a_mode_write: assert property ( // RL16
        i_clk_en & mode_wr_w |=> o_mode == $past(i_instr.mode_val))
        else $error("mode write not taken");

    a_read_keeps_ovf: assert property ( // RL10
        i_clk_en & (load_w | compute_w) & is_read
            |=> ovf_reg == $past(ovf_reg))
        else $error("read-back changed the overflow flag");
endmodule

// ### bench/mac_core_model.sv
// ----------------------------------------------------------------
// core side: issues one instruction per call, pulses low when idle
// ----------------------------------------------------------------
module mac_core_model (
    // clock
    input wire logic i_core_clk,
    // instruction to the block
    output mac_pkg::instr_t o_instr,
    output logic o_clk_en
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        o_instr = '0;
        o_clk_en = 1'b1;
    end

    // callers write the mode before its operands
    // and init, mode, computes, read-back in that order
    task automatic drive(input logic en, input mac_pkg::instr_t ins);
        @(negedge i_core_clk);
        o_clk_en = en;
        o_instr = ins;
        @(posedge i_core_clk);
    endtask

    // drop the pulses so a held instruction is not taken twice
    task automatic idle();
        @(negedge i_core_clk);
        o_instr = '0;
        o_clk_en = 1'b1;
    endtask
endmodule

// ### bench/tb_mac_coprocessor_datapath.sv
module tb_mac_coprocessor_datapath;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct {
        logic [15:0] data;
        logic [3:0] flags;
        logic [31:0] acc;
        logic ovf;
        logic [7:0] mode;
        logic [31:0] sec;
    } exp_t;

    logic i_core_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    mac_pkg::instr_t instr;
    logic clk_en;
    mac_pkg::answer_t ans;
    logic [31:0] acc_o;
    logic ovf_o;
    logic [7:0] mode_o;
    logic [31:0] sec_o;
    exp_t q[$];
    int miscompares = 0;
    int checked = 0;
    logic [7:0] mode = 8'h00;
    logic [31:0] acc = 32'h0000_0000;
    logic [31:0] sec = 32'h0000_0000;
    logic ovf = 1'b0;
    logic [7:0] mac_modes [4] = '{8'h06, 8'h07, 8'h16, 8'h17};
    logic [7:0] rd_modes [4] = '{8'h03, 8'h13, 8'h23, 8'h33};

    mac_core_model core_u (
        .i_core_clk(i_core_clk),
        .o_instr(instr),
        .o_clk_en(clk_en)
    );

    mac_coprocessor_datapath dut_u (
        .i_core_clk(i_core_clk),
        .i_sys_rst(i_sys_rst),
        .i_clk_en(clk_en),
        .i_instr(instr),
        .o_answer(ans),
        .o_mode(mode_o),
        .o_overflow(ovf_o),
        .o_accumulator(acc_o),
        .o_secondary(sec_o)
    );

    initial begin
        forever #50 i_core_clk = ~i_core_clk;
    end

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic cmp(input string what, input logic [31:0] e, s);
        checked++;
        if (e !== s) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, e, s);
        end
    endtask

    // ----------------------------------------------------------------
    // drive one instruction and note what the block must answer
    // ----------------------------------------------------------------
    task automatic op(input logic en, mw, ld, cp, ie, input logic [7:0] mv,
                      input logic [15:0] d, s, im);
        mac_pkg::instr_t ins;
        logic [15:0] b;
        logic [31:0] p;
        logic [31:0] sm;
        logic ov;
        logic rd;
        exp_t e;
        ins = '{mw, ld, cp, ie, mv, d, s, im};
        b = ie ? im : s;
        rd = mode[3:0] == 4'h3 && mode[7:6] == 2'b00;
        core_u.drive(en, ins);
        if (!en) return;
        if (mw) begin
            mode = mv;
            if (mv == 8'h00) begin
                acc = '0;
                sec = '0;
                ovf = 1'b0;
            end
        end else if (ld) begin
            if (mode == 8'h01) acc = {16'h0000, b};
            if (mode == 8'h02) acc = {d, b};
            if (!rd) ovf = 1'b0;
        end else if (cp) begin
            e.flags = 4'h0;
            if (rd) begin
                e.data = mode[4] ? (mode[5] ? sec[31:16] : acc[31:16])
                                 : (mode[5] ? sec[15:0] : acc[15:0]);
            end else begin
                if (mode[7:5] == 3'b000 && mode[3:1] == 3'b011 && !ovf) begin
                    if (mode[0]) p = $signed(d) * $signed(b);
                    else p = d * b;
                    sm = p + acc;
                    ov = mode[0] && p[31] == acc[31] && sm[31] != p[31];
                    acc = sm;
                    ovf = ov;
                    e.flags = ov ? 4'h4 : 4'h0;
                end else begin
                    ovf = 1'b0;
                end
                e.data = mode[4] ? acc[31:16] : acc[15:0];
            end
            e.acc = acc;
            e.ovf = ovf;
            e.mode = mode;
            e.sec = sec;
            q.push_back(e);
        end
    endtask

    task automatic wr(input logic [7:0] m);
        op(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, m, 16'h0000, 16'h0000, 16'h0000);
    endtask

    task automatic ca(input logic [15:0] d, s);
        op(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 8'h00, d, s, 16'h0000);
    endtask

    // ----------------------------------------------------------------
    // answer watcher
    // ----------------------------------------------------------------
    always @(negedge i_core_clk) begin
        exp_t e;
        if (!i_sys_rst && ans.valid === 1'b1) begin
            if (q.size() == 0) begin
                cmp("unexpected answer", 32'h0000_0000, 32'h0000_0001);
            end else begin
                e = q.pop_front();
                cmp("answer data", 32'(e.data), 32'(ans.data));
                cmp("answer flags", 32'(e.flags), 32'(ans.flags));
                cmp("accumulator", e.acc, acc_o);
                cmp("overflow", 32'(e.ovf), 32'(ovf_o));
                cmp("mode", 32'(e.mode), 32'(mode_o));
                cmp("secondary", e.sec, sec_o);
            end
        end
    end

    initial begin
        #400_000;
        miscompares++;
        test_done();
    end

    initial begin
        void'($urandom(85482));
        repeat (10) @(posedge i_core_clk);
        @(negedge i_core_clk);
        i_sys_rst = 1'b0;
        wr(8'h00);
        wr(8'h07);
        ca(16'h0003, 16'hFFFE);
        wr(8'h13);
        ca(16'h0000, 16'h0000);
        for (int i = 0; i < 16; i++) begin
            wr(mac_modes[i % 4]);
            ca(16'($urandom), 16'($urandom));
            op(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 8'h00, 16'($urandom),
               16'($urandom), 16'($urandom));
        end
        wr(8'h01);
        op(1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 8'h00, 16'h1234, 16'h5555,
           16'hABCD);
        wr(8'h02);
        op(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 8'h00, 16'h7FFF, 16'hFFF0,
           16'h0000);
        wr(8'h07);
        ca(16'h0100, 16'h0100);
        ca(16'h0001, 16'h0001);
        ca(16'h0001, 16'h0001);
        wr(8'h02);
        op(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 8'h00, 16'h8000, 16'h0000,
           16'h0000);
        wr(8'h17);
        ca(16'h8000, 16'h0001);
        wr(8'h06);
        ca(16'hFFFF, 16'hFFFF);
        ca(16'h7FFF, 16'h7FFF);
        for (int i = 0; i < 4; i++) begin
            wr(rd_modes[i]);
            ca(16'h0000, 16'h0000);
            ca(16'h0000, 16'h0000);
        end
        op(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 8'h00, 16'h0000, 16'h0000,
           16'h0000);
        ca(16'h0000, 16'h0000);
        wr(8'h08);
        ca(16'h0005, 16'h0005);
        wr(8'h00);
        wr(8'h13);
        ca(16'h0000, 16'h0000);
        core_u.idle();
        repeat (4) @(negedge i_core_clk);
        cmp("pending answers", 32'h0000_0000, 32'(q.size()));
        test_done();
    end
endmodule
